// >>> design/afe_mux_sequencer.sv
/*
  Input multiplexer sequencer of a metering front end: steps the input
  selection through regular or alternate frames, starts conversions, stores
  decimator results into compute-engine data memory, drives the reference
  chopper and gates the cell-measure load. Registers sit on an APB slave.
  Assumes all inputs are synchronous to pclk, the slow crystal clock arrives
  as a sampled level, and the decimator result is valid when a conversion ends.
*/
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "afe_mux_sequencer_consts.svh"

module afe_mux_sequencer
  import afe_mux_sequencer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slow_crystal_clock,
  input wire logic main_power_ok,
  input wire logic [21:0] decim_result,
  output logic [1:0] mux_state,
  output logic alternate_frame,
  output logic conv_start,
  output logic mem_we,
  output logic [6:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic frame_sync,
  output logic reference_swap_signal,
  output logic battery_load_en
);

  seq_state_s st_q;
  seq_state_s st_d;
  logic tick;
  logic apb_acc;
  logic apb_done;
  logic [1:0] last_state;
  logic [1:0] last_conv;
  logic sum_last;
  logic alt_rise;

  // ----------------------------------------
  // Slot and frame decode
  // ----------------------------------------
  function automatic logic [6:0] slot_of(input logic alt, input logic [1:0] s);
    logic [6:0] a;
    a = {5'h00, s};
    if (alt && s == 2'h0) begin
      a = `SLOT_TEMP;
    end else if (alt && s == 2'h2) begin
      a = `SLOT_BATT;
    end
    // State 1 keeps phase one voltage in both frame kinds
    return a;
  endfunction : slot_of

  // Reserved counts above four clamp to four so a bad write cannot overrun
  always_comb begin
    if (st_q.nstates_cfg > 3'h4) begin
      last_state = 2'h3;
    end else if (st_q.nstates_cfg < 3'h2) begin
      last_state = 2'h1;
    end else begin
      last_state = st_q.nstates_cfg[1:0] - 2'h1;
    end
  end

  assign tick = slow_crystal_clock & ~st_q.slow_q;
  assign last_conv = st_q.dec_len ? 2'h2 : 2'h1;
  assign sum_last = (st_q.frame_cnt + 8'h01 >= st_q.sum_frames);
  assign apb_acc = psel & penable & ~st_q.pready;
  assign apb_done = psel & penable & st_q.pready;
  // Only a written 0-to-1 change of the request bit counts as a new request
  assign alt_rise = apb_done & pwrite & (paddr == `CTRL_OFS) & pwdata[`CTRL_ALT_BIT]
                    & ~st_q.alt_req;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.slow_q = slow_crystal_clock;
    st_d.conv_start = 1'b0;
    st_d.mem_we = 1'b0;
    st_d.pready = apb_acc;
    st_d.pslverr = 1'b0;
    st_d.prdata = 32'h0000_0000;
    if (apb_acc && !pwrite) begin
      if (paddr == `CTRL_OFS) begin
        st_d.prdata[`CTRL_NST_MSB:`CTRL_NST_LSB] = st_q.nstates_cfg;
        st_d.prdata[`CTRL_DEC_BIT] = st_q.dec_len;
        st_d.prdata[`CTRL_CHOP_MSB:`CTRL_CHOP_LSB] = st_q.chop_mode;
        st_d.prdata[`CTRL_CME_BIT] = st_q.cme;
        st_d.prdata[`CTRL_ALT_BIT] = st_q.alt_req;
        st_d.prdata[`CTRL_EQU_MSB:`CTRL_EQU_LSB] = st_q.formula;
      end else if (paddr == `STAT_OFS) begin
        st_d.prdata = {16'h0000, st_q.frame_cnt, st_q.batt_en, st_q.swap,
                       st_q.alt_pending, st_q.alt_active, st_q.seq,
                       st_q.frame_sync, st_q.mux_state};
      end else if (paddr == `SUM_OFS) begin
        st_d.prdata = {24'h000000, st_q.sum_frames};
      end else begin
        st_d.pslverr = 1'b1;
      end
    end else if (apb_acc) begin
      st_d.pslverr = !(paddr == `CTRL_OFS || paddr == `STAT_OFS
                       || paddr == `SUM_OFS);
    end
    if (apb_done && pwrite && paddr == `CTRL_OFS) begin
      st_d.nstates_cfg = pwdata[`CTRL_NST_MSB:`CTRL_NST_LSB];
      st_d.dec_len = pwdata[`CTRL_DEC_BIT];
      st_d.chop_mode = pwdata[`CTRL_CHOP_MSB:`CTRL_CHOP_LSB];
      st_d.cme = pwdata[`CTRL_CME_BIT];
      st_d.alt_req = pwdata[`CTRL_ALT_BIT];
      st_d.formula = pwdata[`CTRL_EQU_MSB:`CTRL_EQU_LSB];
    end else if (apb_done && pwrite && paddr == `SUM_OFS) begin
      st_d.sum_frames = pwdata[7:0];
    end

    if (tick && st_q.seq == SEQ_CONV) begin
      if (st_q.conv_cnt == last_conv) begin
        st_d.conv_cnt = 2'h0;
        st_d.mem_we = 1'b1;
        st_d.mem_addr = slot_of(st_q.alt_active, st_q.mux_state);
        if (st_q.dec_len) begin
          st_d.mem_wdata = {decim_result[21], decim_result, 9'h000};
        end else begin
          st_d.mem_wdata = {{2{decim_result[20]}}, decim_result[20:0], 9'h000};
        end
        if (st_q.mux_state == last_state) begin
          st_d.seq = SEQ_SETTLE;
          st_d.frame_sync = 1'b1;
          st_d.frame_cnt = sum_last ? 8'h00 : st_q.frame_cnt + 8'h01;
          case (st_q.chop_mode)
            CHOP_REV: st_d.swap = 1'b1;
            CHOP_TOGGLE: st_d.swap = sum_last ? st_q.swap : ~st_q.swap;
            default: st_d.swap = 1'b0;
          endcase
        end else begin
          st_d.mux_state = st_q.mux_state + 2'h1;
          st_d.conv_start = 1'b1;
        end
      end else begin
        st_d.conv_cnt = st_q.conv_cnt + 2'h1;
      end
    end else if (tick) begin
      st_d.seq = SEQ_CONV;
      st_d.frame_sync = 1'b0;
      st_d.mux_state = 2'h0;
      st_d.conv_cnt = 2'h0;
      st_d.conv_start = 1'b1;
      st_d.alt_active = st_q.alt_pending;
      st_d.alt_pending = 1'b0;
    end
    // A request rising in the boundary cycle survives the clear
    if (alt_rise) begin
      st_d.alt_pending = 1'b1;
    end
    st_d.batt_en = st_q.cme & main_power_ok;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.nstates_cfg <= `NST_RST;
      st_q.dec_len <= `DEC_RST;
      st_q.sum_frames <= `SUM_RST;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign mux_state = st_q.mux_state;
  assign alternate_frame = st_q.alt_active;
  assign conv_start = st_q.conv_start;
  assign mem_we = st_q.mem_we;
  assign mem_addr = st_q.mem_addr;
  assign mem_wdata = st_q.mem_wdata;
  assign frame_sync = st_q.frame_sync;
  assign reference_swap_signal = st_q.swap;
  assign battery_load_en = st_q.batt_en;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_alt_temp_slot: assert property (
    mem_we && alternate_frame && $past(mux_state) == 2'h0 |-> mem_addr == `SLOT_TEMP)
    else $error("alternate state 0 not stored at temperature slot");
  a_batt_gate: assert property (
    battery_load_en |-> $past(main_power_ok) && $past(st_q.cme))
    else $error("battery load on without enable and power");
  a_va_kept: assert property (
    mem_we && $past(mux_state) == 2'h1 |-> mem_addr == 7'h01)
    else $error("phase one voltage slot replaced");
  a_state_cap: assert property (
    $rose(frame_sync) |-> $past(mux_state) <= last_state)
    else $error("frame ran beyond configured states");
  a_frame_start: assert property (
    $fell(frame_sync) |-> mux_state == 2'h0 && conv_start)
    else $error("frame did not start at state 0");
  a_sync_hold: assert property (
    frame_sync && !tick |=> frame_sync)
    else $error("frame sync dropped between slow edges");
  a_sync_rise: assert property (
    $rose(frame_sync) |-> $past(tick))
    else $error("frame sync not raised on a slow edge");
  a_shift_nine: assert property (
    mem_we |-> mem_wdata[8:0] == 9'h000)
    else $error("stored result not shifted by nine");
  a_swap_fixed: assert property (
    $rose(frame_sync) && $past(st_q.chop_mode) == CHOP_POS |-> !reference_swap_signal)
    else $error("swap not low in positive mode");
  a_alt_once: assert property (
    $changed(alternate_frame) |-> $past(frame_sync))
    else $error("frame kind changed off a boundary");

  // ----------------------------------------
  // Sequencer timing
  // ----------------------------------------
  // Every step of the sequencer must trace back to a slow clock edge

  a_sync_drop: assert property (
    frame_sync && tick && clk_en
    |=> !frame_sync && conv_start)
    else $error("settle cycle not ended by the next slow edge");

  a_mux_on_tick: assert property (
    $changed(mux_state)
    |-> $past(tick))
    else $error("mux state moved without a slow edge");

  a_start_on_tick: assert property (
    conv_start
    |-> $past(tick))
    else $error("conversion start off a slow edge");

  a_we_on_tick: assert property (
    mem_we
    |-> $past(tick) && $past(st_q.seq) == SEQ_CONV)
    else $error("result stored outside a conversion");

  a_conv_len: assert property (
    mem_we
    |-> $past(st_q.conv_cnt) == ($past(st_q.dec_len) ? 2'h2 : 2'h1))
    else $error("conversion length wrong for decimator setting");

  a_mux_order: assert property (
    $changed(mux_state) && !$fell(frame_sync)
    |-> mux_state == $past(mux_state) + 2'h1)
    else $error("mux state skipped a position");

  a_dec_short: assert property (
    mem_we && !$past(st_q.dec_len)
    |-> mem_wdata[31:29] == {3{mem_wdata[29]}})
    else $error("short result not sign extended");

  a_slot_regular: assert property (
    mem_we && !alternate_frame
    |-> mem_addr == {5'h00, $past(mux_state)})
    else $error("regular result stored at wrong slot");

  // ----------------------------------------
  // Alternate frames, chopper and cell load
  // ----------------------------------------
  // Swap may only move on a frame boundary, never inside a frame

  a_batt_slot: assert property (
    mem_we && alternate_frame && $past(mux_state) == 2'h2
    |-> mem_addr == `SLOT_BATT)
    else $error("cell result not stored at slot 07");

  a_alt_start: assert property (
    $rose(alternate_frame)
    |-> $fell(frame_sync) && $past(st_q.alt_pending))
    else $error("alternate frame started without a request");

  a_alt_regular: assert property (
    $fell(frame_sync) && !$past(st_q.alt_pending)
    |-> !alternate_frame)
    else $error("alternate frame repeated");

  a_alt_latch: assert property (
    alt_rise && clk_en
    |=> st_q.alt_pending)
    else $error("alternate request not latched");

  a_swap_rev: assert property (
    $rose(frame_sync) && $past(st_q.chop_mode) == CHOP_REV
    |-> reference_swap_signal)
    else $error("swap not high in reverse mode");

  a_swap_edge: assert property (
    $changed(reference_swap_signal)
    |-> $rose(frame_sync))
    else $error("swap changed inside a frame");

  a_chop_hold: assert property (
    $rose(frame_sync) && $past(st_q.chop_mode) == CHOP_TOGGLE && $past(sum_last)
    |-> $stable(reference_swap_signal))
    else $error("swap toggled at end of accumulation");

  a_chop_flip: assert property (
    $rose(frame_sync) && $past(st_q.chop_mode) == CHOP_TOGGLE && !$past(sum_last)
    |-> $changed(reference_swap_signal))
    else $error("swap did not toggle in chop mode");

  a_no_power: assert property (
    $past(clk_en) && !$past(main_power_ok)
    |-> !battery_load_en)
    else $error("cell load on without main power");

  a_cell_off: assert property (
    $past(clk_en) && !$past(st_q.cme)
    |-> !battery_load_en)
    else $error("cell load on with enable cleared");

  // ----------------------------------------
  // Bus and clock enable
  // ----------------------------------------
  // A frozen block must not lose a half-seen slow edge or bus access

  a_freeze: assert property ( // clock enable holds all state
    !$past(clk_en)
    |-> $stable(st_q))
    else $error("state moved while clock enable low");

  a_ready_pulse: assert property ( // one-cycle bus answer
    pready
    |=> !pready)
    else $error("ready held longer than one cycle");

  a_err_with_ready: assert property ( // error only with the answer
    pslverr
    |-> pready)
    else $error("bus error without ready");

  a_rdata_idle: assert property ( // read data zero outside the answer
    !pready
    |-> prdata == 32'h0000_0000)
    else $error("read data driven outside the answer");

  c_batt_write: cover property (mem_we && mem_addr == `SLOT_BATT);
  c_chop_toggle: cover property ($rose(frame_sync) ##[1:8] $changed(reference_swap_signal));
  c_three_state: cover property ($rose(frame_sync) && $past(mux_state) == 2'h2);
  c_alt_frame: cover property ($rose(alternate_frame));
  c_bus_error: cover property (pready && pslverr);

endmodule : afe_mux_sequencer

// >>> design/afe_mux_sequencer_consts.svh
/*
  Offsets, field positions, reset values and slot addresses of the front-end
  sequencer. Assumes a byte-addressed APB register window of 12 bits.
*/
`ifndef AFE_MUX_SEQUENCER_CONSTS_SVH
`define AFE_MUX_SEQUENCER_CONSTS_SVH

`define CTRL_OFS 12'h000
`define STAT_OFS 12'h004
`define SUM_OFS 12'h008

`define CTRL_NST_LSB 0
`define CTRL_NST_MSB 2
`define CTRL_DEC_BIT 3
`define CTRL_CHOP_LSB 4
`define CTRL_CHOP_MSB 5
`define CTRL_CME_BIT 6
`define CTRL_ALT_BIT 7
`define CTRL_EQU_LSB 8
`define CTRL_EQU_MSB 9

`define NST_RST 3'h4
`define DEC_RST 1'h1
`define SUM_RST 8'h01

`define SLOT_TEMP 7'h06
`define SLOT_BATT 7'h07
`define RESULT_SHIFT 9

`endif

// >>> design/afe_mux_sequencer_pkg.sv
/*
  Types of the front-end sequencer: sequence phase, chopper mode and the
  packed state record. Assumes the constants header is compiled alongside.
*/
package afe_mux_sequencer_pkg;

  typedef enum logic [0:0] {
    SEQ_SETTLE = 1'b0,
    SEQ_CONV = 1'b1
  } seq_e;

  typedef enum logic [1:0] {
    CHOP_POS = 2'b00,
    CHOP_REV = 2'b01,
    CHOP_TOGGLE = 2'b10
  } chop_e;

  typedef struct packed {
    logic slow_q;
    seq_e seq;
    logic [1:0] mux_state;
    logic [1:0] conv_cnt;
    logic alt_active;
    logic alt_pending;
    logic [7:0] frame_cnt;
    logic swap;
    logic frame_sync;
    logic conv_start;
    logic mem_we;
    logic [6:0] mem_addr;
    logic [31:0] mem_wdata;
    logic batt_en;
    logic [2:0] nstates_cfg;
    logic dec_len;
    logic [1:0] chop_mode;
    logic cme;
    logic alt_req;
    logic [1:0] formula;
    logic [7:0] sum_frames;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } seq_state_s;

endpackage : afe_mux_sequencer_pkg

// >>> tb/afe_partner.sv
/*
  Model of the engine data memory and the decimator that feed the sequencer.
  Assumes writes arrive as one-pclk mem_we pulses on pclk.
*/
`timescale 1ns/100ps
module afe_partner (
  input wire logic pclk,
  input wire logic [1:0] mux_state,
  input wire logic alternate_frame,
  input wire logic mem_we,
  input wire logic [6:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic [21:0] decim_result
);
  logic [31:0] mem [0:127];
  logic [27:0] ord = 28'h0;
  // Result depends on the source, so a misrouted slot shows in memory
  assign decim_result = {2'b10, 16'h5A3C, alternate_frame, mux_state, 1'b1};
  always @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_addr] <= mem_wdata;
      ord <= {ord[20:0], mem_addr};
    end
  end
endmodule : afe_partner

// >>> tb/afe_mux_sequencer_tb.sv
/*
  Self-checking bench of the front-end sequencer over APB.
  Assumes a fast slow-clock (16 pclk) so whole frames fit in a short run.
*/
`timescale 1ns/100ps
module afe_mux_sequencer_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, pwr = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata, mem_wdata;
  logic er, pready, pslverr, alternate_frame, conv_start, mem_we, frame_sync, swap, batt;
  logic fs_d = 0, sw, ce = 1;
  logic [10:0] fz;
  logic [1:0] mux_state;
  logic [6:0] mem_addr;
  logic [21:0] decim;
  logic [3:0] sc = 4'h0;
  int n_fail = 0, compares = 0, gap = 0, lgap = 0, nc = 0, lnc = 0, t;
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    sc <= sc + 4'h1;
    slow <= sc[3];
    gap <= conv_start ? 1 : gap + 1;
    if (conv_start) lgap <= gap;
    fs_d <= frame_sync;
    if (frame_sync && !fs_d) begin
      lnc <= nc;
      nc <= 0;
    end else nc <= nc + int'(conv_start);
  end
  afe_mux_sequencer afe_mux_sequencer_inst (.pclk(pclk), .presetn(presetn), .clk_en(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .slow_crystal_clock(slow),
    .main_power_ok(pwr), .decim_result(decim), .mux_state(mux_state),
    .alternate_frame(alternate_frame), .conv_start(conv_start), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .frame_sync(frame_sync),
    .reference_swap_signal(swap), .battery_load_en(batt));
  afe_partner afe_partner_inst (.pclk(pclk), .mux_state(mux_state),
    .alternate_frame(alternate_frame), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .decim_result(decim));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic results;
    $display("compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h", $time, m, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_fail++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Waits for the next frame boundary, bounded by 900 pclk, over four long frames
  task automatic wsync;
    int i;
    i = 0;
    while (frame_sync !== 1'b0 && i < 900) begin
      @(posedge pclk);
      i++;
    end
    while (frame_sync !== 1'b1 && i < 900) begin
      @(posedge pclk);
      i++;
    end
    if (i >= 900) begin
      n_fail++;
      results();
    end
    repeat (4) @(posedge pclk);
  endtask : wsync
  function automatic logic [31:0] ew(input logic d, input logic a, input logic [1:0] s);
    logic [21:0] r;
    r = {2'b10, 16'h5A3C, a, s, 1'b1};
    ew = d ? {r[21], r, 9'h000} : {r[20], r[20], r[20:0], 9'h000};
  endfunction : ew
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 32'h0);
    chk(rd, 32'h0000000C, "ctrl reset");
    apb(0, 12'h008, 32'h0);
    chk(rd, 32'h00000001, "sum reset");
    apb(0, 12'hFFC, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    apb(1, 12'hFFC, 32'hFFFFFFFF);
    chk({31'h0, er}, 32'h1, "unmapped write");
    $display("test registers done");
    apb(1, 12'h008, 32'h2);
    apb(1, 12'h000, 32'h30C);
    apb(0, 12'h000, 32'h0);
    chk(rd, 32'h0000030C, "ctrl readback");
    wsync();
    wsync();
    chk({4'h0, afe_partner_inst.ord}, {4'h0, 7'h00, 7'h01, 7'h02, 7'h03}, "order");
    chk(afe_partner_inst.mem[2], ew(1, 0, 2), "slot data");
    chk(lgap, 48, "conv length");
    chk(lnc, 4, "conv count");
    chk({31'h0, swap}, 32'h0, "positive swap");
    $display("test frames done");
    apb(1, 12'h000, 32'h1C);
    wsync();
    chk({31'h0, swap}, 32'h1, "reverse swap");
    apb(1, 12'h000, 32'h2C);
    wsync();
    t = 0;
    for (int k = 0; k < 4; k++) begin
      sw = swap;
      wsync();
      t += int'(sw != swap);
    end
    chk(t, 2, "chop toggles");
    $display("test chop done");
    apb(1, 12'h000, 32'h02);
    wsync();
    wsync();
    chk({18'h0, afe_partner_inst.ord[13:0]}, {18'h0, 7'h00, 7'h01}, "short order");
    chk(lgap, 32, "short conv");
    chk(lnc, 2, "short count");
    chk(afe_partner_inst.mem[1], ew(0, 0, 1), "short data");
    $display("test short done");
    apb(1, 12'h000, 32'h4C);
    repeat (3) @(posedge pclk);
    chk({31'h0, batt}, 32'h1, "load on");
    apb(1, 12'h000, 32'hCC);
    apb(1, 12'h000, 32'h4C);
    wsync();
    wsync();
    chk({4'h0, afe_partner_inst.ord}, {4'h0, 7'h06, 7'h01, 7'h07, 7'h03}, "alt order");
    chk(afe_partner_inst.mem[7], ew(1, 1, 2), "cell slot");
    chk(afe_partner_inst.mem[1], ew(1, 1, 1), "alt voltage");
    wsync();
    chk({4'h0, afe_partner_inst.ord}, {4'h0, 7'h00, 7'h01, 7'h02, 7'h03}, "one alt");
    pwr <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, batt}, 32'h0, "load no power");
    $display("test alternate done");
    ce <= 1'b0;
    repeat (2) @(posedge pclk);
    fz = {frame_sync, alternate_frame, mux_state, mem_addr};
    repeat (40) @(posedge pclk);
    chk({21'h0, frame_sync, alternate_frame, mux_state, mem_addr}, {21'h0, fz}, "frozen");
    ce <= 1'b1;
    $display("test freeze done");
    results();
  end
endmodule : afe_mux_sequencer_tb
